// >>> hw/clock_timer_defs.svh
`ifndef CLOCK_TIMER_DEFS_SVH
`define CLOCK_TIMER_DEFS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define CT_ADDR_STAGE     8'hE4
`define CT_ADDR_EN        8'hEB
`define CT_ADDR_FLAG      8'hEF
`define CT_ADDR_CTRL      8'hF9
`define CT_ADDR_FLAG_CLR  8'hD0

// ****************************************************************
// Widths and field positions
// ****************************************************************
`define CT_ADDR_W         8
`define CT_DATA_W         4
`define CT_DIV_W          7
`define CT_PRESC_W        19
`define CT_FLAG_W         3
`define CT_STAGE_LSB      3
`define CT_STAGE_MSB      6
`define CT_TAP_FIRST      2
`define CT_TAP_STEP       2
`define CT_CLR_BIT        2

// ****************************************************************
// Reset values
// ****************************************************************
`define CT_DIV_RST        7'h00
`define CT_PRESC_RST      19'h00000
`define CT_FLAG_RST       3'h0
`define CT_DATA_RST       4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define CT_CLK_PERIOD_NS  8
`define CT_TICK_PERIOD_NS 3906250
`define CT_TICK_CYCLES    (`CT_TICK_PERIOD_NS / `CT_CLK_PERIOD_NS)

`endif

// >>> hw/clock_timer_pkg.sv
`include "clock_timer_defs.svh"

package clock_timer_pkg;

  typedef logic [`CT_ADDR_W-1:0] addr_t;
  typedef logic [`CT_DATA_W-1:0] nib_t;
  typedef logic [`CT_FLAG_W-1:0] flag_t;
  typedef logic [`CT_DIV_W-1:0]  div_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_STAGE, SEL_EN, SEL_FLAG, SEL_CTRL, SEL_CLR
  } sel_t;

  typedef struct packed {
    logic [`CT_PRESC_W-1:0] presc;
    div_t                   cnt;
    div_t                   fall;
  } div_state_t;

  typedef struct packed {
    flag_t en;
    flag_t flags;
    nib_t  rdata;
  } ct_state_t;

endpackage : clock_timer_pkg

// >>> hw/tick_if.sv
`timescale 1ns/1ps

// Carries the divider state between register logic and divider
interface tick_if;
  import clock_timer_pkg::*;
  logic ce;
  logic clear;
  div_t stages;
  div_t fall;

  modport ctl (output ce, output clear, input stages, input fall);
  modport div (input ce, input clear, output stages, output fall);
endinterface : tick_if

// >>> hw/tick_divider.sv
`timescale 1ns/1ps
`include "clock_timer_defs.svh"

module tick_divider #(
  parameter int TICK_CYCLES = `CT_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  tick_if.div       t
);
  import clock_timer_pkg::*;

  div_state_t s_q;
  div_state_t s_d;
  div_t       nxt;

  // ****************************************************************
  // Prescaler to 256 Hz and seven-stage binary divider
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    nxt = s_q.cnt + 7'h01;
    if (t.ce) begin
      s_d.fall = '0;
      if (s_q.presc == `CT_PRESC_W'(TICK_CYCLES - 1)) begin
        s_d.presc = `CT_PRESC_RST;
      end else begin
        s_d.presc = s_q.presc + `CT_PRESC_W'(1);
      end
      // Clear wins; prescaler keeps running so counting resumes
      if (t.clear) begin
        s_d.cnt = `CT_DIV_RST;
      end else if (s_q.presc == `CT_PRESC_W'(TICK_CYCLES - 1)) begin
        s_d.cnt  = nxt;
        s_d.fall = s_q.cnt & ~nxt;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{presc: `CT_PRESC_RST, cnt: `CT_DIV_RST, fall: `CT_DIV_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign t.stages = s_q.cnt;
  assign t.fall   = s_q.fall;

  // ****************************************************************
  // Checks
  // ****************************************************************
  count_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    t.ce && !t.clear && s_q.presc == `CT_PRESC_W'(TICK_CYCLES - 1)
    |=> t.stages == $past(t.stages) + 7'h01)
    else $error("divider did not advance on tick");

  clear_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    t.ce && t.clear |=> t.stages == `CT_DIV_RST && t.fall == '0)
    else $error("divider not cleared");

endmodule : tick_divider

// >>> hw/clock_timer.sv
`timescale 1ns/1ps
`include "clock_timer_defs.svh"

// Notes on behaviour
// - Seven-bit divider advances on each 256 Hz tick
// - Only four top divider stages are readable
// - Readout bits: 16, 8, 4, 2 Hz
// - Readout is read-only; writes ignored
// - Reset clears divider; readout reads zero
// - Falling 32/8/2 Hz edges set flags
// - Flags set regardless of enable bits
// - Enable register bits 32/8/2 Hz, reads back
// - Reset clears all enable bits
// - Flag register reports events; writes ignored
// - Reading flag register returns then clears flags
// - Reset clears all flags
// - Writing one to clear bit zeroes divider
// - Clear bit is write-only, reads zero

module clock_timer #(
  parameter int TICK_CYCLES = `CT_TICK_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  ce,
  input  wire clock_timer_pkg::addr_t addr,
  input  wire clock_timer_pkg::nib_t  wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output      clock_timer_pkg::nib_t  rdata,
  output      logic                  irq
);
  import clock_timer_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Maps a bus address onto a register select
  function automatic sel_t decode(input addr_t a);
    sel_t s;
    s = SEL_NONE;
    case (a)
      `CT_ADDR_STAGE:    s = SEL_STAGE;
      `CT_ADDR_EN:       s = SEL_EN;
      `CT_ADDR_FLAG:     s = SEL_FLAG;
      `CT_ADDR_CTRL:     s = SEL_CTRL;
      `CT_ADDR_FLAG_CLR: s = SEL_CLR;
      default:           s = SEL_NONE;
    endcase
    return s;
  endfunction : decode

  ct_state_t s_q;
  ct_state_t s_d;
  sel_t      rd_sel;
  sel_t      wr_sel;
  flag_t     evt;
  flag_t     clr;
  nib_t      stage_view;

  tick_if t ();

  // Strobes gated by the select of the current address
  assign rd_sel = rd ? decode(addr) : SEL_NONE;
  assign wr_sel = wr ? decode(addr) : SEL_NONE;

  // ****************************************************************
  // Divider
  // ****************************************************************

  // Divider freezes together with the register logic
  assign t.ce = ce;

  // Clear strobe only from a one in the clear bit
  assign t.clear = ce && wr_sel == SEL_CTRL
                   && wdata[`CT_CLR_BIT];

  tick_divider #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .t       (t.div)
  );

  // Upper four stages, 16 Hz at bit 0 up to 2 Hz at bit 3
  assign stage_view = t.stages[`CT_STAGE_MSB:`CT_STAGE_LSB];

  // ****************************************************************
  // Tick events
  // ****************************************************************

  // Flag i follows the falling edge of tap 2 + 2*i
  for (genvar i = 0; i < `CT_FLAG_W; i++) begin : g_evt
    assign evt[i] = t.fall[`CT_TAP_FIRST + `CT_TAP_STEP * i];
  end

  // ****************************************************************
  // Flag clear sources
  // ****************************************************************

  // Read of the flag register or a one in the clear register
  always_comb begin
    clr = '0;
    if (rd_sel == SEL_FLAG) begin
      clr = '1;
    end else if (wr_sel == SEL_CLR) begin
      clr = wdata[`CT_FLAG_W-1:0];
    end
  end

  // ****************************************************************
  // Register logic
  // ****************************************************************

  // Next state of enables, flags and read data
  always_comb begin
    s_d = s_q;
    if (ce) begin
      // Read data stands for one cycle only
      s_d.rdata = `CT_DATA_RST;
      case (rd_sel)
        SEL_STAGE: s_d.rdata = stage_view;
        SEL_EN:    s_d.rdata = {1'b0, s_q.en};
        SEL_FLAG:  s_d.rdata = {1'b0, s_q.flags};
        SEL_CTRL:  s_d.rdata = `CT_DATA_RST;
        default:   s_d.rdata = `CT_DATA_RST;
      endcase
      // Set wins over clear; enables do not gate the set
      s_d.flags = (s_q.flags & ~clr) | evt;
      // Writes to readout and flag register fall to no branch
      case (wr_sel)
        SEL_EN:  s_d.en = wdata[`CT_FLAG_W-1:0];
        default: s_d.en = s_q.en;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // All timer interrupts masked, no events pending
      s_q <= '{en: `CT_FLAG_RST, flags: `CT_FLAG_RST,
               rdata: `CT_DATA_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Read data from the register
  assign rdata = s_q.rdata;

  // Level request from any enabled flag
  assign irq = |(s_q.flags & s_q.en);

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!reset_n);

  // Readout follows the upper divider stages
  stage_read_a: assert property (
    ce && rd_sel == SEL_STAGE
    |=> rdata == $past(t.stages[`CT_STAGE_MSB:`CT_STAGE_LSB]))
    else $error("readout does not match divider stages");

  // Readout write leaves the divider alone
  stage_ro_a: assert property (
    ce && wr_sel == SEL_STAGE && t.fall == '0 && $past(t.fall) == '0
    ##1 ce && !t.clear && t.fall == '0
    |-> $stable(t.stages) || t.stages == $past(t.stages) + 7'h01)
    else $error("write to readout disturbed divider");

  // Reset leaves the divider at zero
  reset_zero_a: assert property (
    $rose(reset_n) |-> t.stages == `CT_DIV_RST)
    else $error("divider not zero after reset");

  // Event edge sets its flag in the next cycle
  edge_flag_a: assert property (
    ce && evt[0] |=> s_q.flags[0])
    else $error("32 Hz edge did not set flag");

  // Masked flag still set by its edge
  masked_set_a: assert property (
    ce && evt[2] && !s_q.en[2] |=> s_q.flags[2] && !s_q.en[2] || wr)
    else $error("masked 2 Hz edge did not set flag");

  // Enable register reads back as written
  enable_back_a: assert property (
    ce && wr_sel == SEL_EN ##1 ce && rd_sel == SEL_EN
    |=> rdata == {1'b0, $past(wdata[`CT_FLAG_W-1:0], 2)})
    else $error("enable readback mismatch");

  // Readback after one idle cycle
  enable_gap_a: assert property (
    ce && wr_sel == SEL_EN ##1 ce && !wr ##1 ce && rd_sel == SEL_EN
    |=> rdata == {1'b0, $past(wdata[`CT_FLAG_W-1:0], 3)})
    else $error("enable readback mismatch after idle cycle");

  // Enables change only on a write to their address
  enable_hold_a: assert property (
    ce && wr_sel != SEL_EN |=> s_q.en == $past(s_q.en))
    else $error("enables changed without a write");

  // Reset leaves enables and flags clear
  reset_mask_a: assert property (
    $rose(reset_n) |-> s_q.en == '0 && s_q.flags == '0 && !irq)
    else $error("enables or flags not clear after reset");

  // Write to the flag register changes nothing
  flag_wr_a: assert property (
    ce && wr_sel == SEL_FLAG && evt == '0 |=> $stable(s_q.flags))
    else $error("write altered flags");

  // Read returns the flags and clears them
  flag_rc_a: assert property (
    ce && rd_sel == SEL_FLAG && evt == '0
    |=> rdata == {1'b0, $past(s_q.flags)} && s_q.flags == '0)
    else $error("flag read did not return and clear");

  // Clear bit forces the divider to zero
  clear_bit_a: assert property (
    ce && wr_sel == SEL_CTRL && wdata[`CT_CLR_BIT]
    |=> stage_view == `CT_DATA_RST)
    else $error("clear bit did not zero divider");

  // Control register reads zero in the clear bit
  clear_ro_a: assert property (
    ce && rd_sel == SEL_CTRL |=> rdata[`CT_CLR_BIT] == 1'b0)
    else $error("clear bit read back as one");

  // Request tracks enabled flags
  irq_level_a: assert property (
    (s_q.flags & s_q.en) != '0 |-> irq)
    else $error("request low with enabled flag set");

  // Request stays low with no enabled flag
  irq_quiet_a: assert property (
    (s_q.flags & s_q.en) == '0 |-> !irq)
    else $error("request high with no enabled flag");

  // Unused top bit reads zero
  top_bit_a: assert property (
    ce && (rd_sel == SEL_EN || rd_sel == SEL_FLAG) |=> !rdata[3])
    else $error("unused bit read as one");

  // Frozen clock enable holds all register state
  freeze_regs_a: assert property (
    !ce |=> s_q == $past(s_q))
    else $error("register state moved while frozen");

  // Frozen clock enable holds the divider
  freeze_div_a: assert property (
    !ce |=> t.stages == $past(t.stages))
    else $error("divider moved while frozen");

  // Clear register drops the flags written as one
  clr_reg_a: assert property (
    ce && wr_sel == SEL_CLR && evt == '0
    |=> s_q.flags == ($past(s_q.flags) & ~$past(wdata[`CT_FLAG_W-1:0])))
    else $error("flag clear register misbehaved");

  // An event in the read cycle survives the read-clear
  set_wins_a: assert property (
    ce && rd_sel == SEL_FLAG && evt != '0 |=> s_q.flags == $past(evt))
    else $error("event lost under flag read");

  // Flags rise only from their edge events
  flag_rise_a: assert property (
    ce && evt == '0 |=> (s_q.flags & ~$past(s_q.flags)) == '0)
    else $error("flag rose without an event");

  // Flags hold with no event, read or clear write
  flag_hold_a: assert property (
    ce && evt == '0 && rd_sel != SEL_FLAG && wr_sel != SEL_CLR
    |=> s_q.flags == $past(s_q.flags))
    else $error("flags changed without a cause");

  // 8 Hz and 2 Hz edges set their flags
  mid_flag_a: assert property (
    ce && evt[1] |=> s_q.flags[1])
    else $error("8 Hz edge did not set flag");

  slow_flag_a: assert property (
    ce && evt[2] |=> s_q.flags[2])
    else $error("2 Hz edge did not set flag");

  // Each event follows a falling divider tap
  fast_src_a: assert property (
    $past(ce) && evt[0] |-> $past(t.stages[`CT_TAP_FIRST]) && !t.stages[`CT_TAP_FIRST])
    else $error("32 Hz event without falling tap");

  mid_src_a: assert property (
    $past(ce) && evt[1] |-> $past(t.stages[`CT_TAP_FIRST + `CT_TAP_STEP])
    && !t.stages[`CT_TAP_FIRST + `CT_TAP_STEP])
    else $error("8 Hz event without falling tap");

  slow_src_a: assert property (
    $past(ce) && evt[2] |-> $past(t.stages[`CT_STAGE_MSB]) && !t.stages[`CT_STAGE_MSB])
    else $error("2 Hz event without falling tap");

  // Divider clear raises no event
  clear_quiet_a: assert property (
    ce && t.clear |=> evt == '0)
    else $error("divider clear raised an event");

  // Control register reads all zero
  ctrl_zero_a: assert property (
    ce && rd_sel == SEL_CTRL |=> rdata == `CT_DATA_RST)
    else $error("control register read not zero");

  // 16 Hz stage on bit 0, 2 Hz stage on bit 3
  stage_low_a: assert property (
    ce && rd_sel == SEL_STAGE |=> rdata[0] == $past(t.stages[`CT_STAGE_LSB]))
    else $error("16 Hz stage not on bit 0");

  stage_high_a: assert property (
    ce && rd_sel == SEL_STAGE |=> rdata[3] == $past(t.stages[`CT_STAGE_MSB]))
    else $error("2 Hz stage not on bit 3");

  // Main scenarios
  flag_set_c: cover property (ce && evt[2] ##1 irq);
  flag_read_c: cover property (ce && rd_sel == SEL_FLAG && s_q.flags != '0);
  clear_div_c: cover property (t.clear ##1 t.stages == '0);
  set_clear_c: cover property (ce && rd_sel == SEL_FLAG && evt != '0);
  freeze_c: cover property (!ce ##1 ce);

endmodule : clock_timer

// >>> tb/cpu_bus_model.sv
`timescale 1ns/1ps

// CPU side of the register bus, driving one-cycle strobes
module cpu_bus_model (
  input  wire logic                    clk,
  input  wire logic                    irq,
  output      clock_timer_pkg::addr_t  addr,
  output      clock_timer_pkg::nib_t   wdata,
  output      logic                    wr,
  output      logic                    rd
);
  import clock_timer_pkg::*;

  logic interrupts_disabled_state;

  // Interrupts never taken, so every access runs in the masked state
  initial begin
    interrupts_disabled_state = 1'b1;
    addr = 8'h00;
    wdata = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Write strobe for one cycle, then one idle cycle
  task automatic write_reg(input addr_t a, input nib_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
    @(posedge clk);
  endtask : write_reg

  // Read strobe for one cycle; data stands in the following cycle
  task automatic read_reg(input addr_t a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
  endtask : read_reg
endmodule : cpu_bus_model

// >>> tb/clock_timer_tb.sv
`timescale 1ns/1ps
`include "clock_timer_defs.svh"

module clock_timer_tb;
  import clock_timer_pkg::*;

  localparam int TICKS = 4;

  logic   clk;
  logic   reset_n;
  logic   ce;
  logic   wr;
  logic   rd;
  logic   irq;
  logic   rd_seen;
  addr_t  addr;
  nib_t   wdata;
  nib_t   rdata;
  nib_t   r;
  int     fails;
  int     n_tests;
  int     cyc;
  int     seed;
  nib_t   exp_q[$];
  string  name_q[$];

  // ****************************************************************
  // Clock, design and bus model
  // ****************************************************************
  initial clk = 1'b0;
  always #4 clk = ~clk;

  clock_timer #(.TICK_CYCLES(TICKS)) u_dut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

  cpu_bus_model u_cpu (.clk(clk), .irq(irq), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string what, input nib_t e, input nib_t got);
    n_tests++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Note the expected read data, then issue the read
  task automatic rd_chk(input addr_t a, input nib_t e, input string what);
    exp_q.push_back(e);
    name_q.push_back(what);
    u_cpu.read_reg(a);
  endtask : rd_chk

  task automatic at(input int t);
    while (cyc < t) @(posedge clk);
  endtask : at

  // Read data watcher, cycle count and hang limit
  always @(posedge clk) begin
    if (rd_seen) begin
      check(name_q.pop_front(), exp_q.pop_front(), rdata);
    end
    rd_seen <= rd;
    if (reset_n) begin
      cyc <= cyc + 1;
    end
    if (cyc > 2000) begin
      fails++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 31740;
    reset_n = 1'b0;
    ce = 1'b1;
    cyc = 0;
    fails = 0;
    n_tests = 0;
    rd_seen = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`CT_ADDR_STAGE, 4'h0, "stage");
    rd_chk(`CT_ADDR_EN, 4'h0, "enables");
    rd_chk(`CT_ADDR_FLAG, 4'h0, "flags");
    rd_chk(`CT_ADDR_CTRL, 4'h0, "control");
    rd_chk(8'h10, 4'h0, "unmapped");
    u_cpu.write_reg(`CT_ADDR_STAGE, 4'hF);
    u_cpu.write_reg(`CT_ADDR_FLAG, 4'h7);
    rd_chk(`CT_ADDR_STAGE, 4'h0, "stage");
    repeat (4) begin
      r = 4'($random(seed));
      u_cpu.write_reg(`CT_ADDR_EN, r);
      rd_chk(`CT_ADDR_EN, r & 4'h7, "enables");
    end
    u_cpu.write_reg(`CT_ADDR_EN, 4'h0);
    at(48);
    rd_chk(`CT_ADDR_FLAG, 4'h1, "flags");
    rd_chk(`CT_ADDR_FLAG, 4'h0, "flags");
    at(80);
    rd_chk(`CT_ADDR_STAGE, 4'h2, "stage");
    at(90);
    u_cpu.write_reg(`CT_ADDR_EN, 4'h1);
    at(112);
    check("irq", 4'h1, {3'h0, irq});
    rd_chk(`CT_ADDR_FLAG, 4'h1, "flags");
    check("irq", 4'h0, {3'h0, irq});
    u_cpu.write_reg(`CT_ADDR_EN, 4'h0);
    at(184);
    check("irq", 4'h0, {3'h0, irq});
    rd_chk(`CT_ADDR_FLAG, 4'h3, "flags");
    // Divider clear, then a write of zero that must not clear again
    at(200);
    u_cpu.write_reg(`CT_ADDR_CTRL, 4'h4);
    at(210);
    rd_chk(`CT_ADDR_FLAG, 4'h1, "flags");
    at(216);
    rd_chk(`CT_ADDR_STAGE, 4'h0, "stage");
    at(248);
    rd_chk(`CT_ADDR_STAGE, 4'h1, "stage");
    at(260);
    u_cpu.write_reg(`CT_ADDR_CTRL, 4'h0);
    at(280);
    rd_chk(`CT_ADDR_STAGE, 4'h2, "stage");
    at(300);
    u_cpu.write_reg(`CT_ADDR_EN, 4'h4);
    at(569);
    rd_chk(`CT_ADDR_STAGE, 4'hB, "stage");
    at(730);
    check("irq", 4'h1, {3'h0, irq});
    rd_chk(`CT_ADDR_FLAG, 4'h7, "flags");
    check("irq", 4'h0, {3'h0, irq});
    // Event in the cycle of a flag read: set wins over read-clear
    at(743);
    rd_chk(`CT_ADDR_FLAG, 4'h0, "flags");
    rd_chk(`CT_ADDR_FLAG, 4'h1, "flags");
    // Clear register drops the flags written as one
    at(780);
    u_cpu.write_reg(`CT_ADDR_FLAG_CLR, 4'h1);
    rd_chk(`CT_ADDR_FLAG, 4'h0, "flags");
    // Clock enable low freezes the divider for 40 cycles
    at(790);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    at(835);
    rd_chk(`CT_ADDR_STAGE, 4'h2, "stage");
    // Second reset in mid-run clears divider, enables and flags
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`CT_ADDR_STAGE, 4'h0, "stage");
    rd_chk(`CT_ADDR_EN, 4'h0, "enables");
    rd_chk(`CT_ADDR_FLAG, 4'h0, "flags");
    check("irq", 4'h0, {3'h0, irq});
    // Let the watcher take the last read data first
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule : clock_timer_tb
